// ==== include/jsd_pkg.sv ====
/*
 jump and store-accumulator decode package: opcode patterns, field positions,
 cycle counts and the carrier structs.
 assumes nothing beyond a SystemVerilog package scope.
*/
`default_nettype none
package jsd_pkg;
	localparam int PC_W      = 12;
	localparam int INSN_W    = 12;
	localparam int DATA_W    = 8;
	localparam int FILE_W    = 5;
	localparam int IMM_W     = 9;
	localparam int PAGE_W    = 3;
	localparam int PAGE_LSB  = 9;
	localparam logic [2:0] JMP_PREFIX   = 3'h5;
	localparam int JMP_PREFIX_LSB = 9;
	localparam logic [6:0] STA_PREFIX   = 7'h01;
	localparam int STA_PREFIX_LSB = 5;
	localparam logic [1:0] JMP_CYC_COMPAT = 2'h2;
	localparam logic [1:0] JMP_CYC_TURBO  = 2'h3;
	localparam logic [1:0] CYC_ONE        = 2'h1;
	localparam logic [PC_W-1:0] PC_RESET  = 12'h000;

	typedef enum logic [1:0] {
		JSD_IDLE = 2'b00,
		JSD_WAIT = 2'b01
	} jsd_state_t;

	typedef struct packed {
		logic              valid;
		logic [INSN_W-1:0] word;
	} jsd_insn_t;

	typedef struct packed {
		logic              we;
		logic [FILE_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} jsd_fwr_t;

	typedef struct packed {
		logic              is_jmp;
		logic              is_sta;
		logic [IMM_W-1:0]  imm;
		logic [FILE_W-1:0] file;
	} jsd_dec_t;
endpackage
`default_nettype wire

// ==== logic/jsd_decode.sv ====
/*
 combinational opcode decoder for the jump and store-accumulator words.
 assumes an instruction word already registered on the core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module jsd_decode (
	// instruction in
	input  wire logic [jsd_pkg::INSN_W-1:0] word,
	// decoded fields
	output jsd_pkg::jsd_dec_t               dec
);
	always_comb begin
		dec.is_jmp = (word[jsd_pkg::INSN_W-1:jsd_pkg::JMP_PREFIX_LSB]
			== jsd_pkg::JMP_PREFIX); // RULE1
		dec.imm    = word[jsd_pkg::IMM_W-1:0]; // RULE1
		dec.is_sta = (word[jsd_pkg::INSN_W-1:jsd_pkg::STA_PREFIX_LSB]
			== jsd_pkg::STA_PREFIX); // RULE5
		dec.file   = word[jsd_pkg::FILE_W-1:0]; // RULE5
	end
endmodule
`default_nettype wire

// ==== logic/jsd_core.sv ====
/*
 execute stage for the jump and store-accumulator instructions.
 assumes fetch hands one word per cycle with a valid flag while ready is high,
 and that the page bits, accumulator and flags come from the core on the same clock.
*/
// How it works
// RULE1: a word whose top three bits are 101 is a jump whose low nine bits are the target.
// RULE2: a jump loads program counter bits 8:0 from the nine-bit immediate target.
// RULE3: a jump loads program counter bits 11:9 from the three page-select bits.
// RULE4: a jump occupies two cycles in compatible mode and three in pipelined mode.
// RULE5: the store-accumulator prefix with a five-bit file field writes the accumulator there.
// RULE6: the store-accumulator instruction leaves the accumulator unchanged.
// RULE7: neither instruction alters a status flag, and the store finishes in one cycle.
`timescale 1ns/100ps
`default_nettype none
module jsd_core (
	// clock and reset
	input  wire logic                         clock,
	input  wire logic                         rst_b,
	// instruction stream
	input  wire jsd_pkg::jsd_insn_t           insn,
	output logic                              insn_ready,
	// core state
	input  wire logic                         turbo_mode,
	input  wire logic [jsd_pkg::PAGE_W-1:0]   page_select_bits,
	input  wire logic [jsd_pkg::DATA_W-1:0]   acc_in,
	input  wire logic [jsd_pkg::DATA_W-1:0]   flags_in,
	// results
	output logic [jsd_pkg::PC_W-1:0]          program_counter,
	output logic                              pc_load,
	output jsd_pkg::jsd_fwr_t                 file_wr,
	output logic [jsd_pkg::DATA_W-1:0]        acc_out,
	output logic [jsd_pkg::DATA_W-1:0]        flags_out
);
	typedef struct packed {
		jsd_pkg::jsd_state_t          st;
		logic [1:0]                   cnt;
		logic                         ready;
		logic [jsd_pkg::PC_W-1:0]     pc;
		logic                         pc_load;
		jsd_pkg::jsd_fwr_t            fwr;
		logic [jsd_pkg::DATA_W-1:0]   acc;
		logic [jsd_pkg::DATA_W-1:0]   flags;
	} jsd_core_state_t;

	jsd_core_state_t   s_r;
	jsd_core_state_t   s_nxt;
	jsd_pkg::jsd_dec_t dec;

	function automatic logic [1:0] jsd_jmp_cycles(input logic turbo);
		jsd_jmp_cycles = turbo ? jsd_pkg::JMP_CYC_TURBO : jsd_pkg::JMP_CYC_COMPAT;
	endfunction

	function automatic logic [jsd_pkg::PC_W-1:0] jsd_pc_inc(
		input logic [jsd_pkg::PC_W-1:0] pc);
		jsd_pc_inc = pc + jsd_pkg::PC_W'(1);
	endfunction

	jsd_decode u_dec (
		.word (insn.word),
		.dec  (dec)
	);

	always_comb begin
		s_nxt         = s_r;
		s_nxt.pc_load = 1'b0;
		s_nxt.fwr.we  = 1'b0;
		s_nxt.acc     = acc_in; // RULE6
		s_nxt.flags   = flags_in; // RULE7
		case (s_r.st)
			jsd_pkg::JSD_IDLE: begin
				if (insn.valid && dec.is_jmp) begin
					s_nxt.pc      = {page_select_bits, dec.imm}; // RULE2 RULE3
					s_nxt.pc_load = 1'b1;
					s_nxt.cnt     = jsd_jmp_cycles(turbo_mode) - jsd_pkg::CYC_ONE; // RULE4
					s_nxt.ready   = 1'b0;
					s_nxt.st      = jsd_pkg::JSD_WAIT;
				end else if (insn.valid && dec.is_sta) begin
					s_nxt.fwr.we   = 1'b1; // RULE5 RULE7
					s_nxt.fwr.addr = dec.file;
					s_nxt.fwr.data = acc_in;
					s_nxt.pc       = jsd_pc_inc(s_r.pc);
				end else if (insn.valid) begin
					s_nxt.pc = jsd_pc_inc(s_r.pc);
				end
			end
			jsd_pkg::JSD_WAIT: begin
				s_nxt.cnt = s_r.cnt - jsd_pkg::CYC_ONE;
				if (s_r.cnt == jsd_pkg::CYC_ONE) begin // RULE4
					s_nxt.ready = 1'b1;
					s_nxt.st    = jsd_pkg::JSD_IDLE;
				end
			end
			default: begin
				s_nxt.st    = jsd_pkg::JSD_IDLE;
				s_nxt.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_r.st      <= jsd_pkg::JSD_IDLE;
			s_r.cnt     <= '0;
			s_r.ready   <= 1'b1;
			s_r.pc      <= jsd_pkg::PC_RESET;
			s_r.pc_load <= 1'b0;
			s_r.fwr     <= '0;
			s_r.acc     <= '0;
			s_r.flags   <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign insn_ready      = s_r.ready;
	assign program_counter = s_r.pc;
	assign pc_load         = s_r.pc_load;
	assign file_wr         = s_r.fwr;
	assign acc_out         = s_r.acc;
	assign flags_out       = s_r.flags;

	// opcode classes taken straight from the word, apart from the decoder
	logic op_jmp;
	logic op_sta;
	assign op_jmp = (insn.word[jsd_pkg::INSN_W-1:jsd_pkg::JMP_PREFIX_LSB]
		== jsd_pkg::JMP_PREFIX);
	assign op_sta = (insn.word[jsd_pkg::INSN_W-1:jsd_pkg::STA_PREFIX_LSB]
		== jsd_pkg::STA_PREFIX);

	// jump target: page bits above, immediate below
	property p_jmp_target;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && dec.is_jmp) |=>
			(program_counter == {$past(page_select_bits), $past(insn.word[jsd_pkg::IMM_W-1:0])})
			&& pc_load;
	endproperty
	a_jmp_target: assert property (p_jmp_target) else $error("jump target wrong"); // RULE2

	property p_jmp_page;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && dec.is_jmp) |=>
			program_counter[jsd_pkg::PC_W-1:jsd_pkg::PAGE_LSB] == $past(page_select_bits);
	endproperty
	a_jmp_page: assert property (p_jmp_page) else $error("jump page bits wrong"); // RULE3

	property p_jmp_decode;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && op_jmp) |=> pc_load;
	endproperty
	a_jmp_decode: assert property (p_jmp_decode) else $error("jump not decoded"); // RULE1

	property p_jmp_compat;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && dec.is_jmp && !turbo_mode) |=> !insn_ready ##1 insn_ready;
	endproperty
	a_jmp_compat: assert property (p_jmp_compat) else $error("compat jump not two cycles"); // RULE4

	property p_jmp_turbo;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && dec.is_jmp && turbo_mode) |=>
			!insn_ready [*2] ##1 insn_ready;
	endproperty
	a_jmp_turbo: assert property (p_jmp_turbo) else $error("turbo jump not three cycles"); // RULE4

	property p_sta_write;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && op_sta) |=>
			file_wr.we && file_wr.addr == $past(insn.word[jsd_pkg::FILE_W-1:0])
			&& file_wr.data == $past(acc_in);
	endproperty
	a_sta_write: assert property (p_sta_write) else $error("store write wrong"); // RULE5

	property p_sta_acc;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && dec.is_sta) |=> acc_out == $past(acc_in);
	endproperty
	a_sta_acc: assert property (p_sta_acc) else $error("accumulator modified"); // RULE6

	property p_no_flags;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && dec.is_sta) |=> flags_out == $past(flags_in) && insn_ready;
	endproperty
	a_no_flags: assert property (p_no_flags) else $error("flags changed or store stalled"); // RULE7

	// jump leaves the status flags alone
	property p_jmp_flags;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && op_jmp) |=>
			flags_out == $past(flags_in);
	endproperty
	a_jmp_flags: assert property (p_jmp_flags) else $error("jump changed flags"); // RULE7

	property p_jmp_no_write;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && op_jmp) |=>
			!file_wr.we;
	endproperty
	a_jmp_no_write: assert property (p_jmp_no_write) else $error("jump wrote"); // RULE1

	property p_sta_no_jump;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && op_sta) |=>
			!pc_load;
	endproperty
	a_sta_no_jump: assert property (p_sta_no_jump) else $error("store loaded pc"); // RULE5

	// other words neither jump nor write
	property p_other_quiet;
		@(posedge clock) disable iff (!rst_b)
		(s_r.ready && insn.valid && !op_jmp && !op_sta) |=>
			!pc_load && !file_wr.we;
	endproperty
	a_other_quiet: assert property (p_other_quiet) else $error("other word acted"); // RULE1

	// stall: words refused, counter held
	property p_stall_quiet;
		@(posedge clock) disable iff (!rst_b)
		!s_r.ready |=>
			!pc_load && !file_wr.we;
	endproperty
	a_stall_quiet: assert property (p_stall_quiet) else $error("taken in stall"); // RULE4

	property p_stall_pc;
		@(posedge clock) disable iff (!rst_b)
		!s_r.ready |=>
			$stable(program_counter);
	endproperty
	a_stall_pc: assert property (p_stall_pc) else $error("pc moved in stall"); // RULE4

	property p_load_pulse;
		@(posedge clock) disable iff (!rst_b)
		pc_load |=>
			!pc_load;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("load not a pulse"); // RULE4
endmodule
`default_nettype wire

// ==== test/jump_and_store_decode_tb_top.sv ====
/*
 self-checking bench for jsd_core: table of jump, store and other words, then back-to-back stores,
 words refused during a jump stall and a reset dropped inside a jump stall.
 assumes jsd_pkg is compiled first and the assertions live in the design files.
*/
`timescale 1ns/100ps
`default_nettype none
module jump_and_store_decode_tb_top;
	typedef struct packed {
		logic [11:0] word;
		logic        turbo;
		logic [2:0]  page;
		logic [7:0]  acc;
		logic        jmp;
		logic        sta;
		logic [11:0] pc;
		logic [11:0] stall;
	} jsd_row_t;
	logic                clock = 1'b0;
	logic                rst_b = 1'b0;
	jsd_pkg::jsd_insn_t  insn = '0;
	logic                turbo_mode = 1'b0;
	logic [2:0]          page_select_bits = 3'h0;
	logic [7:0]          acc_in = 8'h3c;
	logic [7:0]          flags_in = 8'hc3;
	logic                insn_ready;
	logic [11:0]         program_counter;
	logic                pc_load;
	jsd_pkg::jsd_fwr_t   file_wr;
	logic [7:0]          acc_out;
	logic [7:0]          flags_out;
	int                  err_total = 0;
	int                  tests_run = 0;
	int                  i;
	int                  n;
	jsd_row_t            rows [8] = '{
		'{12'ha00, 1'b0, 3'h7, 8'h00, 1'b1, 1'b0, 12'he00, 12'h001},
		'{12'hbff, 1'b1, 3'h0, 8'hff, 1'b1, 1'b0, 12'h1ff, 12'h002},
		'{12'hb55, 1'b0, 3'h5, 8'h81, 1'b1, 1'b0, 12'hb55, 12'h001},
		'{12'h03f, 1'b0, 3'h2, 8'ha5, 1'b0, 1'b1, 12'h000, 12'h000},
		'{12'h020, 1'b1, 3'h6, 8'h5a, 1'b0, 1'b1, 12'h000, 12'h000},
		'{12'h8ff, 1'b0, 3'h1, 8'h12, 1'b0, 1'b0, 12'h000, 12'h000},
		'{12'h01f, 1'b0, 3'h3, 8'h34, 1'b0, 1'b0, 12'h000, 12'h000},
		'{12'h05f, 1'b1, 3'h4, 8'h56, 1'b0, 1'b0, 12'h000, 12'h000}};

	jsd_core u_dut (.clock(clock), .rst_b(rst_b), .insn(insn), .insn_ready(insn_ready),
		.turbo_mode(turbo_mode), .page_select_bits(page_select_bits), .acc_in(acc_in),
		.flags_in(flags_in), .program_counter(program_counter), .pc_load(pc_load),
		.file_wr(file_wr), .acc_out(acc_out), .flags_out(flags_out));

	initial begin
		forever #25 clock = ~clock;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask

	// one word per row, outputs looked at 1ns after the edge that takes it
	task automatic issue(input jsd_row_t r);
		@(posedge clock);
		insn <= '{1'b1, r.word};
		turbo_mode <= r.turbo;
		page_select_bits <= r.page;
		acc_in <= r.acc;
		flags_in <= ~r.acc;
		@(posedge clock);
		insn.valid <= 1'b0;
		#1;
		chk("pc_load", {11'h0, r.jmp}, {11'h0, pc_load});
		if (r.jmp) chk("pc", r.pc, program_counter);
		chk("we", {11'h0, r.sta}, {11'h0, file_wr.we});
		if (r.sta) chk("addr", {7'h0, r.word[4:0]}, {7'h0, file_wr.addr});
		if (r.sta) chk("data", {4'h0, r.acc}, {4'h0, file_wr.data});
		chk("acc_out", {4'h0, r.acc}, {4'h0, acc_out});
		chk("flags_out", {4'h0, ~r.acc}, {4'h0, flags_out});
		n = 0;
		while (insn_ready !== 1'b1 && n < 8) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("stall", r.stall, n[11:0]);
		if (n == 8) complete_run();
	endtask

	initial begin
		repeat (2) @(posedge clock);
		#1;
		chk("rst_pc", 12'h000, program_counter);
		chk("rst_ctl", 12'h001, {9'h0, pc_load, file_wr.we, insn_ready});
		chk("rst_acc", 12'h000, {4'h0, acc_out});
		chk("rst_flags", 12'h000, {4'h0, flags_out});
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		for (i = 0; i < 8; i++) issue(rows[i]);
		// back-to-back stores, each write a single pulse
		@(posedge clock);
		insn <= '{1'b1, 12'h023};
		acc_in <= 8'h11;
		@(posedge clock);
		insn <= '{1'b1, 12'h024};
		acc_in <= 8'h22;
		#1;
		chk("we_a", 12'hb11, {file_wr.we, file_wr.addr[2:0], file_wr.data});
		@(posedge clock);
		insn.valid <= 1'b0;
		#1;
		chk("we_b", 12'hc22, {file_wr.we, file_wr.addr[2:0], file_wr.data});
		chk("acc_b", 12'h022, {4'h0, acc_out});
		@(posedge clock);
		#1;
		chk("we_end", 12'h000, {11'h0, file_wr.we});
		// store offered during a pipelined jump stall is ignored
		@(posedge clock);
		insn <= '{1'b1, 12'ha12};
		turbo_mode <= 1'b1;
		page_select_bits <= 3'h2;
		@(posedge clock);
		insn <= '{1'b1, 12'h03f};
		#1;
		chk("pc_t", 12'h412, program_counter);
		for (i = 0; i < 3; i++) begin
			@(posedge clock);
			if (i == 1) insn.valid <= 1'b0;
			#1;
			chk("we_refused", 12'h000, {10'h0, pc_load, file_wr.we});
		end
		chk("pc_hold", 12'h412, program_counter);
		// reset dropped inside a pipelined jump stall, then a fresh jump
		@(posedge clock);
		insn <= '{1'b1, 12'hbff};
		@(posedge clock);
		insn.valid <= 1'b0;
		#1;
		chk("pc_mid", 12'h5ff, program_counter);
		@(posedge clock);
		rst_b <= 1'b0;
		#1;
		chk("mid_pc", 12'h000, program_counter);
		chk("mid_ctl", 12'h001, {9'h0, pc_load, file_wr.we, insn_ready});
		chk("mid_data", 12'h000, {4'h0, acc_out | flags_out});
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		issue(rows[0]);
		complete_run();
	end
endmodule
`default_nettype wire
